/* File: verilog/dcr_io_decode.sv */
// Purpose: Control-board address decode and register load for the 8-bit processor
// Assumes: Processor bus strobes are one-cycle pulses synchronous to clk_i
// Notes:   Refresh-memory requests are issued with the committed register value; plane_enable_o shows a new mask one cycle later
`default_nettype none
module dcr_io_decode
    import dcr_pkg::*;
#(
    parameter int PLANES   = 12,
    parameter int IRQ_BITS = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire dcr_cpu_req_s     cpu_req_i,
    input  wire logic [11:0]      readback_data_i,
    input  wire logic [15:0]      system_condition_i,
    input  wire logic [15:0]      option_switches_i,
    output logic [7:0]            rdata_o,
    output logic                  rdata_valid_o,
    output logic                  mem_sel_o,
    output logic                  serial_sel_o,
    output logic                  video_sel_o,
    output dcr_refresh_cmd_s      refresh_o,
    output logic [PLANES-1:0]     plane_enable_o,
    output logic [11:0]           foreground_o,
    output logic [11:0]           background_o,
    output logic [7:0]            point_update_o,
    output logic [15:0]           point_x_o,
    output logic [15:0]           point_y_o,
    output logic [9:0]            scroll_x_o,
    output logic [8:0]            scroll_y_o,
    output logic [15:0]           xfer_source_o,
    output logic [15:0]           xfer_dest_o,
    output logic [15:0]           xfer_count_o,
    output logic [15:0]           xfer_addr_o,
    output logic [15:0]           glyph_o,
    output logic [15:0]           host_exchange_o,
    output logic [IRQ_BITS-1:0]   host_irq_lines_o,
    output logic                  host_irq_strobe_o
);

    initial begin
        if (PLANES < 1 || PLANES > 12) begin
            $error("PLANES must lie between 1 and 12");
        end
        if (IRQ_BITS < 1 || IRQ_BITS > 4) begin
            $error("IRQ_BITS must lie between 1 and 4");
        end
    end

    // Address fields
    logic [15:0] addr;
    logic [15:0] base_addr;
    logic [4:0]  idx;
    logic        hi_byte;
    logic        alias_sel;
    logic        ctrl_hit;
    logic        acc_ok;
    logic        wr_go;
    logic        rd_go;

    assign addr      = cpu_req_i.addr;
    assign alias_sel = addr[ALIAS_BIT];
    assign base_addr = alias_sel ? (addr - ALIAS_OFFSET) : addr;
    assign idx       = addr[5:1];
    assign hi_byte   = addr[0];

    // Alias range is the plain range shifted by bit 7
    assign ctrl_hit  = in_range(base_addr, IO_BASE, CTRL_LAST);
    // An alias a register does not own is never acted on
    assign acc_ok    = ctrl_hit && (!alias_sel || has_alias(idx));
    assign wr_go     = cpu_req_i.wr && acc_ok;
    assign rd_go     = cpu_req_i.rd && acc_ok;

    // Space routing, registered per access
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_sel_o <= 1'b0;
        end else begin
            mem_sel_o <= (cpu_req_i.wr || cpu_req_i.rd) && (addr < IO_BASE);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_sel_o <= 1'b0;
        end else begin
            serial_sel_o <= (cpu_req_i.wr || cpu_req_i.rd)
                            && in_range(addr, SERIAL_FIRST, SERIAL_LAST);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            video_sel_o <= 1'b0;
        end else begin
            video_sel_o <= (cpu_req_i.wr || cpu_req_i.rd)
                           && in_range(addr, VIDEO_FIRST, VIDEO_LAST);
        end
    end

    // Byte-pair registers
    logic [NUM_WORDS-1:0][15:0] word_val;
    logic [NUM_WORDS-1:0]       commit_vec;

    for (genvar gi = 0; gi < NUM_WORDS; gi++) begin : g_word
        localparam logic [4:0] WI = 5'(gi);
        if (is_pair_reg(WI)) begin : g_pair
            dcr_byte_pair_reg #(
                .FIELD_MASK (field_mask(WI)),
                .RESET_VAL  ((WI == IDX_MASK) ? RST_PLANES : RST_ZERO),
                .STRICT     (WI == IDX_MASK)
            ) u_reg (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .wr_any_i (cpu_req_i.wr),
                .wr_lo_i  (wr_go && (idx == WI) && !hi_byte),
                .wr_hi_i  (wr_go && (idx == WI) && hi_byte),
                .wdata_i  (cpu_req_i.wdata),
                .commit_o (commit_vec[gi]),
                .value_o  (word_val[gi])
            );
        end else begin : g_none
            assign commit_vec[gi] = 1'b0;
            assign word_val[gi]   = RST_ZERO;
        end
    end

    // Update control needs only its odd address; the even one is ignored
    logic [7:0] update_ctrl_r;
    logic       update_wr;

    assign update_wr = wr_go && (idx == IDX_UPD) && hi_byte;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            update_ctrl_r <= 8'h00;
        end else if (update_wr) begin
            update_ctrl_r <= cpu_req_i.wdata & MASK_UPDATE;
        end
    end

    // Host exchange bytes are independent, each at its own address
    logic [7:0] exch_lo_r;
    logic [7:0] exch_hi_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            exch_lo_r <= 8'h00;
        end else if (wr_go && (addr == OFS_HOST_EXCHANGE_LOW)) begin
            exch_lo_r <= cpu_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            exch_hi_r <= 8'h00;
        end else if (wr_go && (addr == OFS_HOST_EXCHANGE_HIGH)) begin
            exch_hi_r <= cpu_req_i.wdata;
        end
    end

    // Refresh-memory request, raised only by an alias write that completes a load or an alias low-byte readback read
    logic         rf_fire;
    dcr_refresh_e rf_kind;

    always_comb begin
        rf_fire = 1'b0;
        rf_kind = RF_WRITE_MOVE;
        if (alias_sel && wr_go && hi_byte) begin
            if (idx == IDX_UPD) begin
                rf_fire = 1'b1;
                rf_kind = RF_WRITE_MOVE;
            end else if (idx == IDX_STEP) begin
                rf_fire = commit_vec[IDX_STEP];
                rf_kind = RF_MOVE_ONLY;
            end else if (idx == IDX_PX || idx == IDX_PY) begin
                rf_fire = commit_vec[idx];
                rf_kind = RF_MOVE_ONLY;
            end else if (idx == IDX_MASK) begin
                // Plain write of the present foreground through the new mask
                rf_fire = commit_vec[IDX_MASK];
                rf_kind = RF_WRITE_MOVE;
            end else if (is_pair_reg(idx)) begin
                rf_fire = commit_vec[idx];
                rf_kind = RF_WRITE_MOVE;
            end
        end else if (alias_sel && rd_go && (idx == IDX_RDBK) && !hi_byte) begin
            // One fetch per element, started by the low-byte read
            rf_fire = 1'b1;
            rf_kind = RF_READ_MOVE;
        end
    end

    // Request appears together with the committed value, one cycle before plane_enable_o shows a new mask
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            refresh_o <= '{req: 1'b0, kind: RF_WRITE_MOVE};
        end else begin
            refresh_o <= '{req: rf_fire, kind: rf_kind};
        end
    end

    // Local copy of the staged interrupt low byte, so the strobe needs no peek inside
    logic [7:0]  irq_lo_r;
    logic [15:0] irq_next;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_lo_r <= 8'h00;
        end else if (wr_go && (idx == IDX_IRQ) && !hi_byte) begin
            irq_lo_r <= cpu_req_i.wdata;
        end
    end

    assign irq_next = {cpu_req_i.wdata, irq_lo_r} & MASK_IRQ;

    // Interrupt strobe marks a load that sets any line
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_irq_strobe_o <= 1'b0;
        end else begin
            host_irq_strobe_o <= commit_vec[IDX_IRQ]
                                 && (irq_next[IRQ_BITS-1:0] != '0);
        end
    end

    // Read path
    function automatic logic [15:0] read_word(input logic [4:0] i);
        if (i == IDX_RDBK) begin
            return {4'h0, readback_data_i};
        end else if (i == IDX_UPD) begin
            return {update_ctrl_r, 8'h00};
        end else if (i == IDX_HX) begin
            return {exch_hi_r, exch_lo_r};
        end else if (i == IDX_SYS) begin
            return system_condition_i;
        end else if (i == IDX_OPT) begin
            return option_switches_i;
        end else if (i == IDX_STEPW || i == IDX_STEP) begin
            return RST_ZERO;
        end else begin
            return word_val[i];
        end
    endfunction

    logic [15:0] rd_word;

    assign rd_word = read_word(idx);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_go) begin
            rdata_o <= hi_byte ? rd_word[15:8] : rd_word[7:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_valid_o <= 1'b0;
        end else begin
            rdata_valid_o <= rd_go;
        end
    end

    // Outputs taken from register flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            plane_enable_o <= PLANES'(RST_PLANES);
        end else begin
            plane_enable_o <= word_val[IDX_MASK][PLANES-1:0];
        end
    end

    // Mirror flops add one cycle; mask holds since only a full pair commits
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_irq_lines_o <= '0;
        end else begin
            host_irq_lines_o <= word_val[IDX_IRQ][IRQ_BITS-1:0];
        end
    end

    assign foreground_o    = word_val[IDX_FG][11:0];
    assign background_o    = word_val[IDX_BG][11:0];
    assign point_update_o  = update_ctrl_r;
    assign point_x_o       = word_val[IDX_PX];
    assign point_y_o       = word_val[IDX_PY];
    assign scroll_x_o      = word_val[IDX_XORG][9:0];
    assign scroll_y_o      = word_val[IDX_YORG][8:0];
    assign xfer_source_o   = word_val[IDX_SRC];
    assign xfer_dest_o     = word_val[IDX_DST];
    assign xfer_count_o    = word_val[IDX_CNT];
    assign xfer_addr_o     = word_val[IDX_XADR];
    assign glyph_o         = word_val[IDX_GLYPH];
    assign host_exchange_o = {exch_hi_r, exch_lo_r};

    // The mask keeps its value between complete reloads
    // Pulse length of interrupt bits is left to software

endmodule
`default_nettype wire

/* File: verilog/dcr_pkg.sv */
// Purpose: Shared constants and types of the control-board register decode
// Assumes: Byte-wide processor bus, byte addresses, one synchronous clock
// Notes:   Offsets are processor byte addresses; word index is address bits 5..1
`default_nettype none
package dcr_pkg;

    // Address space split
    localparam logic [15:0] IO_BASE       = 16'h8000;
    localparam logic [15:0] CTRL_LAST     = 16'h8027;
    localparam logic [15:0] SERIAL_FIRST  = 16'h8036;
    localparam logic [15:0] SERIAL_LAST   = 16'h805B;
    localparam logic [15:0] VIDEO_FIRST   = 16'h8060;
    localparam logic [15:0] VIDEO_LAST    = 16'h806F;
    localparam logic [15:0] ALIAS_OFFSET  = 16'h0080;
    localparam int          ALIAS_BIT     = 7;

    // Register byte offsets
    localparam logic [15:0] OFS_PLANE_ENABLE_MASK   = 16'h8000;
    localparam logic [15:0] OFS_HOST_INTERRUPT      = 16'h8002;
    localparam logic [15:0] OFS_PIXEL_READBACK      = 16'h8004;
    localparam logic [15:0] OFS_SCROLL_X_ORIGIN     = 16'h8006;
    localparam logic [15:0] OFS_SCROLL_Y_ORIGIN     = 16'h8008;
    localparam logic [15:0] OFS_TRANSFER_SOURCE     = 16'h800A;
    localparam logic [15:0] OFS_TRANSFER_DEST       = 16'h800C;
    localparam logic [15:0] OFS_POINT_UPDATE_CTRL   = 16'h800F;
    localparam logic [15:0] OFS_BACKGROUND_COLOR    = 16'h8010;
    localparam logic [15:0] OFS_FOREGROUND_COLOR    = 16'h8012;
    localparam logic [15:0] OFS_POINT_X_ADDRESS     = 16'h8014;
    localparam logic [15:0] OFS_POINT_Y_ADDRESS     = 16'h8016;
    localparam logic [15:0] OFS_GLYPH_BIT_PATTERN   = 16'h8018;
    localparam logic [15:0] OFS_HOST_EXCHANGE_LOW   = 16'h801A;
    localparam logic [15:0] OFS_HOST_EXCHANGE_HIGH  = 16'h801B;
    localparam logic [15:0] OFS_SYSTEM_CONDITION    = 16'h801C;
    localparam logic [15:0] OFS_TRANSFER_WORD_COUNT = 16'h801E;
    localparam logic [15:0] OFS_TRANSFER_ADDRESS    = 16'h8020;
    localparam logic [15:0] OFS_STEP_AND_WRITE      = 16'h8022;
    localparam logic [15:0] OFS_STEP_WITHOUT_WRITE  = 16'h8024;
    localparam logic [15:0] OFS_OPTION_SWITCHES     = 16'h8026;

    // Word indices
    localparam logic [4:0] IDX_MASK   = OFS_PLANE_ENABLE_MASK[5:1];
    localparam logic [4:0] IDX_IRQ    = OFS_HOST_INTERRUPT[5:1];
    localparam logic [4:0] IDX_RDBK   = OFS_PIXEL_READBACK[5:1];
    localparam logic [4:0] IDX_XORG   = OFS_SCROLL_X_ORIGIN[5:1];
    localparam logic [4:0] IDX_YORG   = OFS_SCROLL_Y_ORIGIN[5:1];
    localparam logic [4:0] IDX_SRC    = OFS_TRANSFER_SOURCE[5:1];
    localparam logic [4:0] IDX_DST    = OFS_TRANSFER_DEST[5:1];
    localparam logic [4:0] IDX_UPD    = OFS_POINT_UPDATE_CTRL[5:1];
    localparam logic [4:0] IDX_BG     = OFS_BACKGROUND_COLOR[5:1];
    localparam logic [4:0] IDX_FG     = OFS_FOREGROUND_COLOR[5:1];
    localparam logic [4:0] IDX_PX     = OFS_POINT_X_ADDRESS[5:1];
    localparam logic [4:0] IDX_PY     = OFS_POINT_Y_ADDRESS[5:1];
    localparam logic [4:0] IDX_GLYPH  = OFS_GLYPH_BIT_PATTERN[5:1];
    localparam logic [4:0] IDX_HX     = OFS_HOST_EXCHANGE_LOW[5:1];
    localparam logic [4:0] IDX_SYS    = OFS_SYSTEM_CONDITION[5:1];
    localparam logic [4:0] IDX_CNT    = OFS_TRANSFER_WORD_COUNT[5:1];
    localparam logic [4:0] IDX_XADR   = OFS_TRANSFER_ADDRESS[5:1];
    localparam logic [4:0] IDX_STEPW  = OFS_STEP_AND_WRITE[5:1];
    localparam logic [4:0] IDX_STEP   = OFS_STEP_WITHOUT_WRITE[5:1];
    localparam logic [4:0] IDX_OPT    = OFS_OPTION_SWITCHES[5:1];
    localparam int         NUM_WORDS  = 20;

    // Field masks and reset values
    localparam logic [15:0] MASK_PLANES   = 16'h0FFF;
    localparam logic [15:0] MASK_IRQ      = 16'h000F;
    localparam logic [15:0] MASK_XORG     = 16'h03FF;
    localparam logic [15:0] MASK_YORG     = 16'h01FF;
    localparam logic [15:0] MASK_FULL     = 16'hFFFF;
    localparam logic [7:0]  MASK_UPDATE   = 8'hF8;
    localparam logic [15:0] RST_PLANES    = 16'h0FFF;
    localparam logic [15:0] RST_ZERO      = 16'h0000;

    typedef enum logic [1:0] {
        RF_WRITE_MOVE,
        RF_READ_MOVE,
        RF_MOVE_ONLY
    } dcr_refresh_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dcr_cpu_req_s;

    typedef struct packed {
        logic         req;
        dcr_refresh_e kind;
    } dcr_refresh_cmd_s;

    // Registers that own an alias with address bit 7 set
    function automatic logic has_alias(input logic [4:0] idx);
        return (idx == IDX_MASK) || (idx == IDX_RDBK) || (idx == IDX_UPD)
            || (idx == IDX_BG) || (idx == IDX_FG) || (idx == IDX_PX)
            || (idx == IDX_PY) || (idx == IDX_STEPW) || (idx == IDX_STEP)
            || (idx == IDX_OPT);
    endfunction

    // Registers built from a staged low byte and a committing high byte
    function automatic logic is_pair_reg(input logic [4:0] idx);
        return (idx == IDX_MASK) || (idx == IDX_IRQ) || (idx == IDX_XORG)
            || (idx == IDX_YORG) || (idx == IDX_SRC) || (idx == IDX_DST)
            || (idx == IDX_BG) || (idx == IDX_FG) || (idx == IDX_PX)
            || (idx == IDX_PY) || (idx == IDX_GLYPH) || (idx == IDX_CNT)
            || (idx == IDX_XADR) || (idx == IDX_STEPW) || (idx == IDX_STEP);
    endfunction

    function automatic logic [15:0] field_mask(input logic [4:0] idx);
        if (idx == IDX_MASK || idx == IDX_BG || idx == IDX_FG) begin
            return MASK_PLANES;
        end else if (idx == IDX_IRQ) begin
            return MASK_IRQ;
        end else if (idx == IDX_XORG) begin
            return MASK_XORG;
        end else if (idx == IDX_YORG) begin
            return MASK_YORG;
        end else begin
            return MASK_FULL;
        end
    endfunction

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

endpackage
`default_nettype wire

/* File: verilog/dcr_byte_pair_reg.sv */
// Purpose: One 16-bit register loaded as a low/high byte pair
// Assumes: At most one bus write per clock
// Notes:   Low byte waits in a staging latch; the high byte commits both bytes
`default_nettype none
module dcr_byte_pair_reg
    import dcr_pkg::*;
#(
    parameter logic [15:0] FIELD_MASK = 16'hFFFF,
    parameter logic [15:0] RESET_VAL  = 16'h0000,
    parameter bit          STRICT     = 1'b0
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_any_i,
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic [7:0]  wdata_i,
    output logic             commit_o,
    output logic [15:0]      value_o
);

    logic [7:0]  stage_r;
    logic        armed_r;
    logic [15:0] value_r;

    // Strict registers refuse a high byte not directly preceded by its low byte
    assign commit_o = wr_hi_i && (armed_r || !STRICT);
    assign value_o  = value_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage_r <= 8'h00;
        end else if (wr_lo_i) begin
            stage_r <= wdata_i;
        end
    end

    // Any other write breaks the back-to-back sequence
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_r <= 1'b0;
        end else if (wr_any_i) begin
            armed_r <= wr_lo_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            value_r <= RESET_VAL & FIELD_MASK;
        end else if (commit_o) begin
            value_r <= {wdata_i, stage_r} & FIELD_MASK;
        end
    end

endmodule
`default_nettype wire

/* File: testbench/dcr_io_decode_asserts.sv */
// Purpose: Port-level assertions for the control-board register decode
// Assumes: One clock, asynchronous active-high reset, one request per cycle
// Notes:   Responses are checked on the edge after the request is taken; interrupt lines one edge after the strobe
`default_nettype none
module dcr_io_decode_asserts
    import dcr_pkg::*;
#(
    parameter int PLANES   = 12,
    parameter int IRQ_BITS = 4
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire dcr_cpu_req_s        cpu_req_i,
    input wire logic                mem_sel_o,
    input wire logic                serial_sel_o,
    input wire logic                video_sel_o,
    input wire dcr_refresh_cmd_s    refresh_o,
    input wire logic [PLANES-1:0]   plane_enable_o,
    input wire logic [IRQ_BITS-1:0] host_irq_lines_o,
    input wire logic                host_irq_strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic        acc = cpu_req_i.wr | cpu_req_i.rd;
    wire logic [15:0] a   = cpu_req_i.addr;
    sequence s_wr(logic [15:0] x); cpu_req_i.wr && a == x; endsequence
    sequence s_irq_pair;
        s_wr(16'h8002) ##0 cpu_req_i.wdata[3:0] != 4'h0 ##1 s_wr(16'h8003);
    endsequence
    property p_mem; acc && a < 16'h8000 |=> mem_sel_o && !serial_sel_o && !video_sel_o; endproperty
    property p_ctl; acc && a >= 16'h8000 && a <= 16'h8026 |=> !(mem_sel_o | serial_sel_o | video_sel_o); endproperty
    property p_ser; acc && a >= 16'h8036 && a <= 16'h805A |=> serial_sel_o && !mem_sel_o; endproperty
    property p_vid; acc && a >= 16'h8060 && a <= 16'h806E |=> video_sel_o && !serial_sel_o; endproperty
    // Mirrors lag one cycle, so after a quiet cycle their next value does not depend on this write
    property p_lo;
        cpu_req_i.wr && (a == 16'h8000 || a == 16'h8002) && !$past(cpu_req_i.wr)
            |=> $stable(plane_enable_o) && $stable(host_irq_lines_o);
    endproperty
    property p_alias; s_wr(16'h8080) ##1 s_wr(16'h8081) |=> refresh_o.req && refresh_o.kind == RF_WRITE_MOVE; endproperty
    property p_plain; cpu_req_i.wr && !a[7] |=> !refresh_o.req; endproperty
    property p_half; s_wr(16'h8080) |=> !refresh_o.req; endproperty
    property p_read; cpu_req_i.rd && a == 16'h8084 |=> refresh_o.req && refresh_o.kind == RF_READ_MOVE; endproperty
    property p_irq; s_irq_pair |=> host_irq_strobe_o ##1 host_irq_lines_o != '0; endproperty
    a_mem: assert property (p_mem) else $error("memory select wrong");
    a_ctl: assert property (p_ctl) else $error("control access routed away");
    a_ser: assert property (p_ser) else $error("serial select wrong");
    a_vid: assert property (p_vid) else $error("video select wrong");
    a_lo: assert property (p_lo) else $error("low byte alone changed a register");
    a_alias: assert property (p_alias) else $error("alias mask load gave no write");
    a_plain: assert property (p_plain) else $error("plain write requested refresh");
    a_half: assert property (p_half) else $error("refresh before full load");
    a_read: assert property (p_read) else $error("readback gave no read refresh");
    a_irq: assert property (p_irq) else $error("interrupt load not signalled");
endmodule
bind dcr_io_decode dcr_io_decode_asserts #(.PLANES(PLANES), .IRQ_BITS(IRQ_BITS)) u_asserts (
    .clk_i, .rst_i, .cpu_req_i, .mem_sel_o, .serial_sel_o, .video_sel_o, .refresh_o,
    .plane_enable_o, .host_irq_lines_o, .host_irq_strobe_o);
`default_nettype wire

/* File: testbench/dcr_gen_model.sv */
// Purpose: Display generator stand-in serving element values and counting requests
// Assumes: Refresh requests are one-cycle pulses
// Notes:   Element value is fixed so reads stay predictable; it never stalls
`default_nettype none
module dcr_gen_model
    import dcr_pkg::*;
#(
    parameter logic [11:0] ELEMENT = 12'h5A3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire dcr_refresh_cmd_s refresh_i,
    output logic [11:0]           readback_o,
    output logic [7:0]            count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign readback_o = ELEMENT;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
        end else if (refresh_i.req) begin
            count_o <= count_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the control-board register decode
// Assumes: One request per cycle, driven 1 ns after the rising edge
// Notes: Unowned aliases are never touched, as software must not
`default_nettype none
module testbench
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_i = 1'h0;
    logic             rst_i = 1'h1;
    dcr_cpu_req_s     req   = '0;
    dcr_refresh_cmd_s rf;
    logic [11:0]      rb, pe, fg, bg;
    logic [9:0]       sx;
    logic [8:0]       sy;
    logic [7:0]       rdata, cnt, upd;
    logic [15:0]      hx;
    logic [3:0]       irq;
    logic             rv, ms, ss, vs, stb;
    int               errors = 0, compares = 0, cycles = 0;
    dcr_io_decode u_dut (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(req), .readback_data_i(rb),
        .system_condition_i(16'h1234), .option_switches_i(16'hA55C), .rdata_o(rdata),
        .rdata_valid_o(rv), .mem_sel_o(ms), .serial_sel_o(ss), .video_sel_o(vs),
        .refresh_o(rf), .plane_enable_o(pe), .foreground_o(fg), .background_o(bg),
        .point_update_o(upd), .point_x_o(), .point_y_o(), .scroll_x_o(sx), .scroll_y_o(sy),
        .xfer_source_o(), .xfer_dest_o(), .xfer_count_o(), .xfer_addr_o(), .glyph_o(),
        .host_exchange_o(hx), .host_irq_lines_o(irq), .host_irq_strobe_o(stb));
    dcr_gen_model u_gen (.clk_i(clk_i), .rst_i(rst_i), .refresh_i(rf), .readback_o(rb),
        .count_o(cnt));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic drive(input logic [1:0] wr_rd, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        req = {wr_rd, a, d};
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d); drive(2'h2, a, d); endtask
    task automatic rd(input logic [15:0] a); drive(2'h1, a, 8'h00); endtask
    task automatic nop; drive(2'h0, 16'h0000, 8'h00); endtask
    task automatic t_mask;
        wr(16'h8000, 8'h34); nop; nop;
        chk(pe, 16'h0FFF);
        wr(16'h8000, 8'h34); wr(16'h8001, 8'h02); nop;
        chk(rf.req, 16'h0000);
        nop;
        chk(pe, 16'h0234);
        wr(16'h8000, 8'h55); wr(16'h8012, 8'hAB); wr(16'h8013, 8'hFC); wr(16'h8001, 8'h0F);
        nop; nop;
        chk(pe, 16'h0234);
        chk(fg, 16'h0CAB);
        wr(16'h8010, 8'hFF); wr(16'h8011, 8'hFF); wr(16'h8006, 8'hFF); wr(16'h8007, 8'hFF);
        wr(16'h8008, 8'hFF); wr(16'h8009, 8'hFF); nop;
        chk(bg, 16'h0FFF);
        chk(sx, 16'h03FF);
        chk(sy, 16'h01FF);
    endtask
    task automatic t_alias;
        wr(16'h8080, 8'h56); wr(16'h8081, 8'hF3); nop;
        chk({rf.req, rf.kind}, {1'h1, RF_WRITE_MOVE});
        nop;
        chk(pe, 16'h0356);
        wr(16'h80A4, 8'h00); wr(16'h80A5, 8'h00); nop;
        chk({rf.req, rf.kind}, {1'h1, RF_MOVE_ONLY});
        rd(16'h8084); nop;
        chk({rv, rdata}, 16'h01A3);
        chk({rf.req, rf.kind}, {1'h1, RF_READ_MOVE});
        rd(16'h8004); nop;
        chk(rf.req, 16'h0000);
        wr(16'h808F, 8'hAF); nop;
        chk({rf.req, rf.kind, upd}, {1'h1, RF_WRITE_MOVE, 8'hA8});
        wr(16'h801A, 8'h12); wr(16'h801B, 8'h34); nop;
        chk(hx, 16'h3412);
        chk(cnt, 16'h0004);
    endtask
    task automatic t_route;
        logic [15:0] adr [8] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h8026,
                                 16'h8036, 16'h805A, 16'h8060, 16'h806E};
        logic [2:0]  sel [8] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h2, 3'h2, 3'h1, 3'h1};
        for (int i = 0; i < 8; i++) begin
            rd(adr[i]); nop;
            chk({ms, ss, vs}, sel[i]);
        end
        rd(16'h80A6); nop;
        chk(rdata, 16'h005C);
    endtask
    task automatic t_irq;
        wr(16'h8002, 8'h05); nop; nop;
        chk(irq, 16'h0000);
        wr(16'h8002, 8'h05); wr(16'h8003, 8'h00); nop;
        chk(stb, 16'h0001);
        nop;
        chk(irq, 16'h0005);
        wr(16'h8002, 8'h00); wr(16'h8003, 8'h00); nop; nop;
        chk(irq, 16'h0000);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        rst_i = 1'h0;
        chk({pe, irq}, 16'hFFF0);
        t_mask;
        t_alias;
        t_route;
        t_irq;
        tally_and_finish;
    end
endmodule
`default_nettype wire
